/* File: include/step_down_regs.vh */
// register offsets, field positions, reset values and timing counts of the step-down bank
`ifndef STEP_DOWN_REGS_VH
`define STEP_DOWN_REGS_VH

// ---------------------------------------------------------------------------
// register offsets (8-bit register address space)
// ---------------------------------------------------------------------------
`define REG_CHARGE_STATE_READBACK 8'h21
`define REG_VBAT_HIGH             8'h25
`define REG_VBAT_LOW              8'h26
`define REG_GAUGE_REFRESH_TRIGGER 8'h28
`define REG_STEP_DOWN_CONFIG      8'h29
`define REG_STEP_DOWN_VOLT_DELAY  8'h2A

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define FLD_REFRESH_BIT      7
`define FLD_SOFT_START_HI    7
`define FLD_SOFT_START_LO    6
`define FLD_PEAK_LIMIT_HI    5
`define FLD_PEAK_LIMIT_LO    4
`define FLD_MODE_BIT         3
`define FLD_PULSE_STOP_BIT   2
`define FLD_DISCHARGE_BIT    1
`define FLD_OUTPUT_EN_BIT    0
`define FLD_DELAY_HI         7
`define FLD_DELAY_LO         6
`define FLD_VCODE_HI         5
`define FLD_VCODE_LO         0

// ---------------------------------------------------------------------------
// reset values (factory-set fields come from the FACTORY_CONFIG and FACTORY_VOLT parameters of the register bank)
// ---------------------------------------------------------------------------
`define RST_PEAK_LIMIT       2'b11
`define RST_PULSE_STOP       1'b0
`define RST_SWITCH_DELAY     2'b00

// ---------------------------------------------------------------------------
// timing: soft start times (ms) and switch delays (us), clock 100 MHz; then output voltage base and step (mV)
// ---------------------------------------------------------------------------
`define CLK_PERIOD_NS        10
`define SS_TIME0_MS          1
`define SS_TIME1_MS          8
`define SS_TIME2_MS          64
`define SS_TIME3_MS          512
`define DLY_TIME1_US         5
`define DLY_TIME2_US         10
`define DLY_TIME3_US         20
`define VOUT_BASE_MV         600
`define VOUT_STEP_MV         50

`endif

/* File: core/step_down_delay_timer.v */
// one-shot timer that counts a loaded number of enable ticks
`timescale 1ns/1ps
module step_down_delay_timer
#(
  parameter W = 16
)
(
  input  wire         i_clk_sys,
  input  wire         i_arst_n,
  input  wire         i_start,
  input  wire         i_tick,
  input  wire [W-1:0] i_count,
  output wire         o_busy,
  output reg          o_done
);

  reg [W-1:0] cnt_ff;
  reg         busy_ff;

  // --------------------------------------------------------------------------
  // counter: start reloads, ticks count down, done pulses one cycle at zero
  // --------------------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cnt_ff  <= {W{1'b0}};
      busy_ff <= 1'b0;
      o_done  <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        cnt_ff  <= i_count;
        busy_ff <= 1'b1;
      end
      else if (busy_ff && i_tick)
      begin
        if (cnt_ff <= {{(W-1){1'b0}}, 1'b1})
        begin
          busy_ff <= 1'b0;
          o_done  <= 1'b1;
          cnt_ff  <= {W{1'b0}};
        end
        else
          cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign o_busy = busy_ff;

endmodule

/* File: core/step_down_config_regs.v */
// register bank that configures the step-down regulator and refreshes gauge readback
// ---------------------------------------------------------------------------
// Notes on behaviour
// - writing one then zero to the refresh bit captures charge state and battery voltage.
// - soft start field selects ramp time 1, 8, 64 or 512 ms.
// - peak limit field decodes 100 to 400 mA, resetting to 400 mA.
// - mode bit zero selects hysteresis, one selects forced pulse width mode.
// - pulse stop bit enables pulse stop; resets to zero.
// - discharge enable bit drives output discharge; reset value is a factory strap.
// - output enable bit turns output on; reset value is a factory strap.
// - in hysteresis, delay field selects 0, 5, 10 or 20 us; resets to 00.
// - voltage code maps 0.6 V plus 50 mV per step to 3.75 V.
// - battery voltage is 13 bits: upper eight in one register, lower five in next.
// ---------------------------------------------------------------------------
`timescale 1ns/1ps
`include "step_down_regs.vh"
module step_down_config_regs
#(
  parameter [7:0] FACTORY_CONFIG = 8'h00,
  parameter [7:0] FACTORY_VOLT   = 8'h00,
  parameter       CLK_MHZ        = 100
)
(
  input  wire        i_clk_sys,
  input  wire        i_arst_n,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  input  wire [7:0]  i_addr,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  output reg         o_rvalid,
  input  wire [7:0]  i_gauge_soc,
  input  wire [12:0] i_gauge_vbat_mv,
  output reg  [1:0]  o_soft_start_sel,
  output reg  [25:0] o_soft_start_cycles,
  output reg  [8:0]  o_peak_limit_ma,
  output reg         o_forced_pulse_width_mode,
  output reg         o_step_down_pulse_stop,
  output reg         o_step_down_discharge_en,
  output reg         o_output_en,
  output reg  [1:0]  o_step_down_switch_delay,
  output wire        o_switch_delay_busy,
  output reg  [5:0]  o_step_down_voltage_code,
  output reg  [11:0] o_vout_mv
);

  // --------------------------------------------------------------------------
  // derived cycle counts
  // --------------------------------------------------------------------------
  // kept 32 bits wide so the products cannot overflow before they are sliced
  localparam [31:0] CYC_PER_US = CLK_MHZ;
  localparam [31:0] CYC_PER_MS = CLK_MHZ * 1000;

  reg  [7:0]  config_ff;
  reg  [7:0]  volt_ff;
  reg         refresh_ff;
  reg  [7:0]  soc_ff;
  reg  [12:0] vbat_ff;
  reg         dly_start_ff;
  reg  [7:0]  nxt_rdata;
  wire [15:0] dly_count;
  wire        dly_start;
  wire        dly_done;
  wire        wr_config;
  wire        wr_volt;
  wire        wr_trigger;
  wire        refresh_fire;

  // soft start ramp length in clock cycles; the longest ramp needs 26 bits
  function [25:0] ss_cycles;
    input [1:0]  sel;
    reg   [31:0] full;
    begin
      case (sel)
        2'b00:   full = `SS_TIME0_MS * CYC_PER_MS;
        2'b01:   full = `SS_TIME1_MS * CYC_PER_MS;
        2'b10:   full = `SS_TIME2_MS * CYC_PER_MS;
        default: full = `SS_TIME3_MS * CYC_PER_MS;
      endcase
      ss_cycles = full[25:0];
    end
  endfunction

  // hysteresis switch delay in clock cycles; code 00 means no delay at all
  function [15:0] dly_cycles;
    input [1:0]  sel;
    reg   [31:0] full;
    begin
      case (sel)
        2'b01:   full = `DLY_TIME1_US * CYC_PER_US;
        2'b10:   full = `DLY_TIME2_US * CYC_PER_US;
        2'b11:   full = `DLY_TIME3_US * CYC_PER_US;
        default: full = 32'h0000_0000;
      endcase
      dly_cycles = full[15:0];
    end
  endfunction

  // write strobe aimed at one register offset
  function wr_hit;
    input       en;
    input [7:0] addr;
    input [7:0] target;
    begin
      wr_hit = en && (addr == target);
    end
  endfunction

  // --------------------------------------------------------------------------
  // write decode, shared by the register update and the delay trigger
  // --------------------------------------------------------------------------
  assign wr_config  = wr_hit(i_wr_en, i_addr, `REG_STEP_DOWN_CONFIG);
  assign wr_volt    = wr_hit(i_wr_en, i_addr, `REG_STEP_DOWN_VOLT_DELAY);
  assign wr_trigger = wr_hit(i_wr_en, i_addr, `REG_GAUGE_REFRESH_TRIGGER);
  // a zero written while the last trigger write held a one ends the sequence
  assign refresh_fire = wr_trigger && refresh_ff && !i_wdata[`FLD_REFRESH_BIT];

  // --------------------------------------------------------------------------
  // register writes; factory fields reload from parameters at reset
  // --------------------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      config_ff  <= {FACTORY_CONFIG[7:6], `RST_PEAK_LIMIT, FACTORY_CONFIG[3],
                     `RST_PULSE_STOP, FACTORY_CONFIG[1:0]};
      volt_ff    <= {`RST_SWITCH_DELAY, FACTORY_VOLT[5:0]};
      refresh_ff <= 1'b0;
      soc_ff     <= 8'h00;
      vbat_ff    <= 13'h0000;
      dly_start_ff <= 1'b0;
    end
    else
    begin
      dly_start_ff <= 1'b0;
      if (wr_config)
        config_ff <= i_wdata;
      if (wr_volt)
      begin
        volt_ff      <= i_wdata;
        dly_start_ff <= 1'b1;     // any write to this register requests the switch delay; it starts only in hysteresis mode with a non-zero delay code
      end
      // only bit 7 is kept; the reserved bits are dropped here
      if (wr_trigger)
        refresh_ff <= i_wdata[`FLD_REFRESH_BIT];
      // gauge values are sampled once per completed one-then-zero sequence
      if (refresh_fire)
      begin
        soc_ff  <= i_gauge_soc;
        vbat_ff <= i_gauge_vbat_mv;
      end
    end
  end

  // --------------------------------------------------------------------------
  // switch delay only applies in hysteresis mode
  // --------------------------------------------------------------------------
  // forced pulse width mode switches at once, so no delay is started there
  assign dly_count = dly_cycles(volt_ff[`FLD_DELAY_HI:`FLD_DELAY_LO]);
  assign dly_start = dly_start_ff && !config_ff[`FLD_MODE_BIT]
                     && (dly_count != 16'h0000);

  step_down_delay_timer #(.W(16)) u_delay
  (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_start   (dly_start),
    .i_tick    (1'b1),                                 // delays count whole clocks
    .i_count   (dly_count),
    .o_busy    (o_switch_delay_busy),
    .o_done    (dly_done)
  );

  // --------------------------------------------------------------------------
  // read mux; reserved bits return zero
  // --------------------------------------------------------------------------
  always @*
  begin
    case (i_addr)
      `REG_CHARGE_STATE_READBACK: nxt_rdata = soc_ff;
      `REG_VBAT_HIGH:             nxt_rdata = vbat_ff[12:5];
      `REG_VBAT_LOW:              nxt_rdata = {vbat_ff[4:0], 3'b000};
      `REG_GAUGE_REFRESH_TRIGGER: nxt_rdata = 8'h00;
      `REG_STEP_DOWN_CONFIG:      nxt_rdata = config_ff;
      `REG_STEP_DOWN_VOLT_DELAY:  nxt_rdata = volt_ff;
      default:                    nxt_rdata = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // registered outputs: read data and decoded regulator controls
  // --------------------------------------------------------------------------
  always @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rdata                   <= 8'h00;
      o_rvalid                  <= 1'b0;
      o_soft_start_sel          <= 2'b00;
      o_soft_start_cycles       <= 26'h000_0000;
      o_peak_limit_ma           <= 9'h000;
      o_forced_pulse_width_mode <= 1'b0;
      o_step_down_pulse_stop    <= 1'b0;
      o_step_down_discharge_en  <= 1'b0;
      o_output_en               <= 1'b0;
      o_step_down_switch_delay  <= 2'b00;
      o_step_down_voltage_code  <= 6'h00;
      o_vout_mv                 <= 12'h000;
    end
    else
    begin
      o_rdata                   <= i_rd_en ? nxt_rdata : o_rdata;
      o_rvalid                  <= i_rd_en;
      o_soft_start_sel          <= config_ff[`FLD_SOFT_START_HI:`FLD_SOFT_START_LO];
      o_soft_start_cycles       <= ss_cycles(config_ff[7:6]);
      o_peak_limit_ma           <= 9'd100 * ({7'h00, config_ff[5:4]} + 9'd1);
      o_forced_pulse_width_mode <= config_ff[`FLD_MODE_BIT];
      o_step_down_pulse_stop    <= config_ff[`FLD_PULSE_STOP_BIT];
      o_step_down_discharge_en  <= config_ff[`FLD_DISCHARGE_BIT];
      o_output_en               <= config_ff[`FLD_OUTPUT_EN_BIT];
      if (dly_done || !o_switch_delay_busy)
        o_step_down_switch_delay <= volt_ff[`FLD_DELAY_HI:`FLD_DELAY_LO];
      o_step_down_voltage_code  <= volt_ff[`FLD_VCODE_HI:`FLD_VCODE_LO];
      o_vout_mv                 <= 12'd600 + 12'd50 * {6'h00, volt_ff[5:0]};
    end
  end

endmodule

/* File: test/step_down_config_regs_props.sv */
// assertions and covers watching the step-down register bank ports
`timescale 1ns/1ps
module step_down_config_regs_props
(
  input wire logic        i_clk_sys,
  input wire logic        i_arst_n,
  input wire logic        i_wr_en,
  input wire logic        i_rd_en,
  input wire logic [7:0]  i_addr,
  input wire logic [7:0]  i_wdata,
  input wire logic [7:0]  o_rdata,
  input wire logic        o_rvalid,
  input wire logic [1:0]  o_soft_start_sel,
  input wire logic [25:0] o_soft_start_cycles,
  input wire logic [8:0]  o_peak_limit_ma,
  input wire logic        o_forced_pulse_width_mode,
  input wire logic        o_step_down_pulse_stop,
  input wire logic        o_step_down_discharge_en,
  input wire logic        o_output_en,
  input wire logic        o_switch_delay_busy,
  input wire logic [5:0]  o_step_down_voltage_code,
  input wire logic [11:0] o_vout_mv
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  logic [7:0] wd1_ff;
  logic [7:0] wd2_ff;
  wire        cfg_wr  = i_wr_en && i_addr == 8'h29;
  wire        volt_wr = i_wr_en && i_addr == 8'h2A;
  // write data two edges back, lining up with the decoded-output latency
  always @(posedge i_clk_sys or negedge i_arst_n)
    if (!i_arst_n)
    begin
      wd1_ff <= 8'h00;
      wd2_ff <= 8'h00;
    end
    else
    begin
      wd1_ff <= i_wdata;
      wd2_ff <= wd1_ff;
    end
  // ----------------------------------------
  // decoded fields follow each config and voltage write; trigger and battery low reads return zero bits
  // ----------------------------------------
  AST_SOFT_START: assert property (cfg_wr |-> ##2 o_soft_start_sel == wd2_ff[7:6] &&
    o_soft_start_cycles == 26'(32'd100000 << (3 * wd2_ff[7:6]))) else $error("soft start");
  AST_PEAK_LIMIT: assert property (cfg_wr |-> ##2
    o_peak_limit_ma == 9'd100 * (wd2_ff[5:4] + 9'd1)) else $error("peak limit");
  AST_MODE_STOP: assert property (cfg_wr |-> ##2
    {o_forced_pulse_width_mode, o_step_down_pulse_stop} == wd2_ff[3:2]) else $error("mode");
  AST_DISCHG_EN: assert property (cfg_wr |-> ##2
    {o_step_down_discharge_en, o_output_en} == wd2_ff[1:0]) else $error("enable");
  AST_VCODE: assert property (volt_wr |-> ##2 o_step_down_voltage_code == wd2_ff[5:0] &&
    o_vout_mv == 12'd600 + 12'd50 * wd2_ff[5:0]) else $error("voltage code");
  AST_TRIG_READ: assert property (i_rd_en && i_addr == 8'h28 |=>
    o_rvalid && o_rdata == 8'h00) else $error("trigger readback");
  AST_VBAT_LOW: assert property (i_rd_en && i_addr == 8'h26 |=>
    o_rdata[2:0] == 3'b000) else $error("battery low bits");
  AST_DELAY_START: assert property (volt_wr && i_wdata[7:6] != 2'b00 &&
    !o_forced_pulse_width_mode && !o_switch_delay_busy |-> ##2 o_switch_delay_busy[*8])
    else $error("switch delay start");
  cover property (cfg_wr ##2 o_forced_pulse_width_mode);
  cover property (volt_wr ##2 o_switch_delay_busy);
  cover property (i_rd_en && i_addr == 8'h25);
endmodule
bind step_down_config_regs step_down_config_regs_props u_step_down_config_regs_props (.*);

/* File: test/step_down_config_regs_bench.sv */
// self-checking bench for the step-down register bank
`timescale 1ns/1ps
module step_down_config_regs_bench;
  localparam logic [12:0] MV = 13'h1A2B;
  logic        i_clk_sys, i_arst_n, i_wr_en, i_rd_en;
  logic [7:0]  i_addr, i_wdata, i_gauge_soc, d;
  logic [12:0] i_gauge_vbat_mv;
  logic [31:0] ex;
  wire  [7:0]  o_rdata;
  wire         o_rvalid, o_forced_pulse_width_mode, o_step_down_pulse_stop;
  wire         o_step_down_discharge_en, o_output_en, o_switch_delay_busy;
  wire  [1:0]  o_soft_start_sel, o_step_down_switch_delay;
  wire  [25:0] o_soft_start_cycles;
  wire  [8:0]  o_peak_limit_ma;
  wire  [5:0]  o_step_down_voltage_code;
  wire  [11:0] o_vout_mv;
  int          errors = 0, compares = 0, n;
  int          codes[4] = '{0, 1, 32, 63};
  step_down_config_regs u_step_down_config_regs (.*);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // every input change lands 1 ns after a rising edge
  task step;
    @(posedge i_clk_sys);
    #1;
  endtask
  // second edge lets the decoded outputs settle
  task wr(input logic [7:0] a, input logic [7:0] v);
    i_wr_en = 1'b1;
    i_addr = a;
    i_wdata = v;
    step;
    i_wr_en = 1'b0;
    step;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] v);
    i_rd_en = 1'b1;
    i_addr = a;
    step;
    i_rd_en = 1'b0;
    chk(o_rvalid, 1);
    chk(o_rdata, v);
    // an edge passes before the next strobe; the valid pulse lasts one cycle
    step;
    chk(o_rvalid, 0);
  endtask
  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  initial
  begin
    {i_arst_n, i_wr_en, i_rd_en, i_addr, i_wdata} = '0;
    i_gauge_soc = 8'h5A;
    i_gauge_vbat_mv = MV;
    repeat (8) step;
    i_arst_n = 1'b1;
    step;
    chk(o_peak_limit_ma, 400);
    rd(8'h29, 8'h30);
    rd(8'h2A, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      d = {i[1:0], i[1:0], i[0], ~i[0], i[1], i[0]};
      wr(8'h29, d);
      ex = 32'd100000 << (3 * i);
      chk(o_soft_start_cycles, ex);
      chk(o_soft_start_sel, i);
      chk(o_peak_limit_ma, 100 * (i + 1));
      chk({o_forced_pulse_width_mode, o_step_down_pulse_stop, o_step_down_discharge_en,
           o_output_en}, d[3:0]);
      rd(8'h29, d);
    end
    // forced pulse width mode is on here, so no switch delay may run
    foreach (codes[k])
    begin
      wr(8'h2A, 8'hC0 | codes[k]);
      chk(o_vout_mv, 600 + 50 * codes[k]);
      chk(o_step_down_voltage_code, codes[k]);
      chk(o_switch_delay_busy, 0);
    end
    wr(8'h29, 8'h30);
    wr(8'h2A, 8'h50);
    step;
    chk(o_switch_delay_busy, 1);
    n = 1;
    while (o_switch_delay_busy === 1'b1 && n < 600)
    begin
      step;
      n++;
    end
    if (n >= 600)
    begin
      errors++;
      give_verdict;
    end
    chk(n, 500);
    chk(o_step_down_switch_delay, 1);
    wr(8'h30, 8'h55);
    rd(8'h30, 8'h00);
    wr(8'h28, 8'h7F);
    rd(8'h28, 8'h00);
    wr(8'h28, 8'h80);
    wr(8'h28, 8'h00);
    rd(8'h21, 8'h5A);
    rd(8'h25, MV[12:5]);
    rd(8'h26, {MV[4:0], 3'b000});
    i_gauge_soc = 8'h11;
    wr(8'h28, 8'h00);
    rd(8'h21, 8'h5A);
    give_verdict;
  end
endmodule
